// ---- hdl/charge_ctrl.sv ----
// Purpose: Charge cycle sequencer for a single lithium cell charger
// Assumes: All sense inputs are comparator levels synchronous to clock
// Notes:   Analog loops follow the drive outputs; this block only decides
`timescale 1ns/100ps

// Functional notes
// - Timeout flag high only in fault state
// - Battery flag mirrors missing cell detection
// - Invalid input forces suspend, switch isolated
// - Each new cycle starts in precondition
// - Precondition current is max(45 mA, fast/10)
// - Precondition threshold reached moves to fast
// - Safety timer expiry in precondition moves to timeout fault
// - Fast charge uses constant current, programmed
// - Termination voltage moves to constant-voltage top-off
// - End of charge needs four uninterrupted minutes
// - Qualified end of charge enters sleep
// - Sleep keeps watching cell voltage
// - Restart drop in sleep starts new cycle
// - Suspend disables charging, logic keeps running
// - Leaving suspend resets timer, enters precondition
// - Fault entry stops charging, sets flag
// - Fault exits only through suspend
// - Active flag and indicator only while charging
// - Safety timer 60, 90, 120 or off
// - Start needs valid input, cell present, no float or suspend
module charge_ctrl #(
  parameter logic [31:0] MINUTE_CYCLES = chg_pkg::MINUTE_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire chg_pkg::chg_sense_t sense,
  input wire logic charge_suspend_request,
  input wire logic [1:0] safety_timer_setting,
  input wire logic [10:0] fast_current_ma,
  output chg_pkg::chg_flags_t flags,
  output chg_pkg::chg_drive_t drive,
  output chg_pkg::chg_state_t charge_state,
  output logic charge_indicator_out,
  output logic charge_indicator_oe_n
);
  import chg_pkg::*;

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    chg_state_t st;
    logic [31:0] tick_cnt;
    logic [6:0] min_cnt;
    logic [2:0] eoc_cnt;
    chg_flags_t flags;
    chg_drive_t drive;
  } ctrl_t;

  ctrl_t state_reg;
  ctrl_t state_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] precond_ma(input logic [10:0] fast);
    logic [10:0] tenth;
    tenth = fast / PRECOND_DIVISOR;
    precond_ma = (tenth > PRECOND_MIN_MA) ? tenth : PRECOND_MIN_MA;
  endfunction

  function automatic logic [6:0] safety_limit(input logic [1:0] sel);
    case (sel)
      TIMER_SET_90: safety_limit = SAFETY_90_MIN;
      TIMER_SET_120: safety_limit = SAFETY_120_MIN;
      default: safety_limit = SAFETY_60_MIN;
    endcase
  endfunction

  function automatic logic is_charging(input chg_state_t s);
    is_charging = (s == ST_PRECOND) || (s == ST_FAST) || (s == ST_TOPOFF);
  endfunction

  logic minute_tick;
  logic start_ok;
  logic supply_lost;
  logic safety_expired;

  assign minute_tick = (state_reg.tick_cnt == MINUTE_CYCLES - 32'h1);
  assign start_ok = sense.input_valid && !sense.current_level_floating &&
                    !charge_suspend_request && sense.battery_present;
  assign supply_lost = !sense.input_valid;
  // selectable safety limit
  // Limit minus one, since the check fires on the tick that completes the last minute
  assign safety_expired = (safety_timer_setting != TIMER_SET_OFF) &&
                          minute_tick &&
                          (state_reg.min_cnt >= safety_limit(safety_timer_setting) - 7'h1);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.tick_cnt = minute_tick ? 32'h0 : state_reg.tick_cnt + 32'h1;
    if (minute_tick && state_reg.min_cnt != 7'h7F) begin
      state_next.min_cnt = state_reg.min_cnt + 7'h1;
    end
    case (state_reg.st)
      ST_SUSPEND: begin
        state_next.tick_cnt = 32'h0;
        state_next.min_cnt = 7'h0;
        state_next.eoc_cnt = 3'h0;
        if (start_ok) begin
          state_next.st = ST_PRECOND;
        end
      end
      ST_PRECOND: begin
        if (!start_ok) begin
          state_next.st = ST_SUSPEND;
        end else if (sense.vbat_above_precond) begin
          state_next.st = ST_FAST;
        end else if (safety_expired) begin
          state_next.st = ST_FAULT;
        end
      end
      ST_FAST: begin
        if (!start_ok) begin
          state_next.st = ST_SUSPEND;
        end else if (sense.vbat_at_term) begin
          state_next.st = ST_TOPOFF;
          state_next.tick_cnt = 32'h0;
          state_next.eoc_cnt = 3'h0;
        end
      end
      ST_TOPOFF: begin
        if (!start_ok) begin
          state_next.st = ST_SUSPEND;
        end else if (!sense.ichg_below_eoc) begin
          state_next.tick_cnt = 32'h0;
          state_next.eoc_cnt = 3'h0;
        end else if (minute_tick) begin
          state_next.eoc_cnt = state_reg.eoc_cnt + 3'h1;
          if (state_reg.eoc_cnt + 3'h1 == EOC_QUAL_MIN) begin
            state_next.st = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (!start_ok) begin
          state_next.st = ST_SUSPEND;
        end else if (sense.vbat_dropped_restart) begin
          state_next.st = ST_PRECOND;
          state_next.tick_cnt = 32'h0;
          state_next.min_cnt = 7'h0;
        end
      end
      ST_FAULT: begin
        if (supply_lost || charge_suspend_request || !sense.battery_present) begin
          state_next.st = ST_SUSPEND;
        end
      end
      default: begin
        state_next.st = ST_SUSPEND;
      end
    endcase
    if (supply_lost) begin
      state_next.st = ST_SUSPEND;
    end
    // Flags and drive follow the next state so they never lag the state
    // fault flag
    state_next.flags.timeout_fault_flag = (state_next.st == ST_FAULT);
    state_next.flags.battery_missing_flag = !sense.battery_present;
    state_next.flags.charging_active_flag = is_charging(state_next.st);
    case (state_next.st)
      ST_PRECOND: begin
        state_next.drive.mode = REG_CC;
        state_next.drive.current_ma = precond_ma(fast_current_ma);
      end
      ST_FAST: begin
        state_next.drive.mode = REG_CC;
        state_next.drive.current_ma = fast_current_ma;
      end
      ST_TOPOFF: begin
        state_next.drive.mode = REG_CV;
        state_next.drive.current_ma = fast_current_ma;
      end
      default: begin
        state_next.drive.mode = REG_OFF;
        state_next.drive.current_ma = ZERO_MA;
      end
    endcase
    state_next.drive.switch_isolate = (state_next.st == ST_SUSPEND) && supply_lost;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // timers cleared on reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '{st: ST_SUSPEND, tick_cnt: 32'h0, min_cnt: 7'h0,
                     eoc_cnt: 3'h0, flags: '0,
                     drive: '{mode: REG_OFF, current_ma: ZERO_MA, switch_isolate: 1'b0}};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign flags = state_reg.flags;
  assign drive = state_reg.drive;
  assign charge_state = state_reg.st;
  // open drain indicator sinks while charging
  assign charge_indicator_out = 1'b0;
  assign charge_indicator_oe_n = !state_reg.flags.charging_active_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence s_in_topoff_low;
    state_reg.st == ST_TOPOFF && sense.ichg_below_eoc && start_ok;
  endsequence

  a_fault_flag_state: assert property (
    flags.timeout_fault_flag == (charge_state == ST_FAULT))
    else $error("fault flag disagrees with state");
  a_batt_flag_follow: assert property (
    $past(arst_n) |-> flags.battery_missing_flag == !$past(sense.battery_present))
    else $error("battery flag not following detection");
  a_supply_to_suspend: assert property (
    !sense.input_valid |=> charge_state == ST_SUSPEND && drive.switch_isolate)
    else $error("supply loss did not suspend");
  a_cycle_start_pre: assert property (
    !is_charging(charge_state) ##1 is_charging(charge_state) |-> charge_state == ST_PRECOND)
    else $error("cycle began outside precondition");
  a_precond_current: assert property (
    charge_state == ST_PRECOND && $stable(fast_current_ma) |->
      drive.current_ma >= PRECOND_MIN_MA && drive.mode == REG_CC)
    else $error("precondition current wrong");
  a_pre_to_fast: assert property (
    state_reg.st == ST_PRECOND && start_ok && sense.vbat_above_precond |=>
      charge_state == ST_FAST)
    else $error("precondition threshold ignored");
  a_fast_cc: assert property (
    charge_state == ST_FAST |-> drive.mode == REG_CC && drive.current_ma == $past(fast_current_ma))
    else $error("fast charge not constant current");
  a_topoff_cv: assert property (
    state_reg.st == ST_FAST && start_ok && sense.vbat_at_term |=>
      charge_state == ST_TOPOFF ##0 drive.mode == REG_CV)
    else $error("termination voltage ignored");
  a_eoc_interrupt: assert property (
    state_reg.st == ST_TOPOFF && start_ok && !sense.ichg_below_eoc |=>
      state_reg.eoc_cnt == 3'h0 && state_reg.tick_cnt == 32'h0)
    else $error("qualification not restarted");
  a_eoc_to_sleep: assert property (
    s_in_topoff_low ##0 minute_tick && state_reg.eoc_cnt == 3'h3 |=>
      charge_state == ST_SLEEP && drive.mode == REG_OFF)
    else $error("end of charge not slept");
  a_fault_no_resume: assert property (
    charge_state == ST_FAULT |=> charge_state inside {ST_FAULT, ST_SUSPEND})
    else $error("fault resumed charging directly");
  a_indicator_active: assert property (
    charge_indicator_oe_n == !is_charging(charge_state))
    else $error("indicator disagrees with state");

  sequence s_fault_entry;
    charge_state == ST_PRECOND ##1 charge_state == ST_FAULT;
  endsequence

  sequence s_suspend_exit;
    charge_state == ST_SUSPEND ##1 charge_state != ST_SUSPEND;
  endsequence

  a_precond_expire: assert property (
    state_reg.st == ST_PRECOND && start_ok && !sense.vbat_above_precond && safety_expired |=>
      charge_state == ST_FAULT)
    else $error("expired precondition did not fault");
  a_fault_source: assert property (
    charge_state != ST_PRECOND && charge_state != ST_FAULT |=> charge_state != ST_FAULT)
    else $error("fault entered from outside precondition");
  a_fault_entry: assert property (
    s_fault_entry |-> flags.timeout_fault_flag && drive.mode == REG_OFF &&
      drive.current_ma == ZERO_MA && charge_indicator_oe_n)
    else $error("fault entry still charging");
  a_timeout_floor: assert property (
    s_fault_entry |-> state_reg.min_cnt >= SAFETY_60_MIN)
    else $error("safety timer expired early");
  a_timer_off: assert property (
    state_reg.st == ST_PRECOND && safety_timer_setting == TIMER_SET_OFF |=>
      charge_state != ST_FAULT)
    else $error("disabled safety timer faulted");
  a_eoc_four_min: assert property (
    charge_state == ST_TOPOFF ##1 charge_state == ST_SLEEP |->
      $past(state_reg.eoc_cnt) == 3'h3 && $past(minute_tick))
    else $error("end of charge before four minutes");
  a_sleep_hold: assert property (
    state_reg.st == ST_SLEEP && start_ok && !sense.vbat_dropped_restart |=>
      charge_state == ST_SLEEP)
    else $error("sleep left without restart");
  a_sleep_restart: assert property (
    state_reg.st == ST_SLEEP && start_ok && sense.vbat_dropped_restart |=>
      charge_state == ST_PRECOND && state_reg.min_cnt == 7'h0 && state_reg.tick_cnt == 32'h0)
    else $error("restart drop ignored in sleep");
  a_suspend_off: assert property (
    charge_state == ST_SUSPEND |->
      drive.mode == REG_OFF && drive.current_ma == ZERO_MA && !flags.charging_active_flag)
    else $error("suspend still charging");
  a_suspend_exit: assert property (
    s_suspend_exit |-> charge_state == ST_PRECOND && state_reg.min_cnt == 7'h0 &&
      state_reg.tick_cnt == 32'h0)
    else $error("suspend exit without timer reset");
  a_auto_start: assert property (
    charge_state == ST_SUSPEND && sense.input_valid && sense.battery_present &&
      !sense.current_level_floating && !charge_suspend_request |=> charge_state == ST_PRECOND)
    else $error("charge cycle did not start");
  a_start_blocked: assert property (
    charge_state == ST_SUSPEND && (sense.current_level_floating || charge_suspend_request) |=>
      charge_state == ST_SUSPEND)
    else $error("blocked start still charged");
  a_charge_suspend: assert property (
    is_charging(charge_state) && charge_suspend_request |=> charge_state == ST_SUSPEND)
    else $error("suspend request ignored while charging");
  a_tick_range: assert property (
    state_reg.tick_cnt < MINUTE_CYCLES)
    else $error("minute prescaler out of range");
  a_tick_wrap: assert property (
    minute_tick |=> state_reg.tick_cnt == 32'h0)
    else $error("minute prescaler did not wrap");
  a_reset_clears: assert property (
    disable iff (1'b0) $rose(arst_n) |-> state_reg.st == ST_SUSPEND &&
      state_reg.tick_cnt == 32'h0 && state_reg.min_cnt == 7'h0 && state_reg.eoc_cnt == 3'h0)
    else $error("reset left timers running");

endmodule

// ---- inc/chg_pkg.sv ----
// Purpose: Shared types and constants for the charge control state machine
// Assumes: 40 MHz clock, comparator levels synchronous to it
// Notes:   Times kept in their own units, cycle counts derived here
package chg_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam longint unsigned CLOCK_HZ = 64'h0262_5A00;
  localparam longint unsigned MINUTE_S = 64'h3C;
  localparam logic [31:0] MINUTE_CYCLES_DEF = 32'(CLOCK_HZ * MINUTE_S);

  // ----------------------------------------------------------------
  // Timer lengths in minutes
  // ----------------------------------------------------------------
  localparam logic [6:0] SAFETY_60_MIN = 7'h3C;
  localparam logic [6:0] SAFETY_90_MIN = 7'h5A;
  localparam logic [6:0] SAFETY_120_MIN = 7'h78;
  localparam logic [2:0] EOC_QUAL_MIN = 3'h4;

  // ----------------------------------------------------------------
  // Safety timer setting codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TIMER_SET_60 = 2'h0;
  localparam logic [1:0] TIMER_SET_90 = 2'h1;
  localparam logic [1:0] TIMER_SET_120 = 2'h2;
  localparam logic [1:0] TIMER_SET_OFF = 2'h3;

  // ----------------------------------------------------------------
  // Current command
  // ----------------------------------------------------------------
  localparam logic [10:0] PRECOND_MIN_MA = 11'h02D;
  localparam logic [10:0] PRECOND_DIVISOR = 11'h00A;
  localparam logic [10:0] ZERO_MA = 11'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SUSPEND = 3'h0,
    ST_PRECOND = 3'h1,
    ST_FAST = 3'h3,
    ST_TOPOFF = 3'h2,
    ST_SLEEP = 3'h6,
    ST_FAULT = 3'h4
  } chg_state_t;

  typedef enum logic [1:0] {
    REG_OFF = 2'h0,
    REG_CC = 2'h1,
    REG_CV = 2'h2
  } reg_mode_t;

  typedef struct packed {
    logic input_valid;
    logic vbat_above_precond;
    logic vbat_at_term;
    logic ichg_below_eoc;
    logic battery_present;
    logic vbat_dropped_restart;
    logic current_level_floating;
  } chg_sense_t;

  typedef struct packed {
    logic timeout_fault_flag;
    logic battery_missing_flag;
    logic charging_active_flag;
  } chg_flags_t;

  typedef struct packed {
    reg_mode_t mode;
    logic [10:0] current_ma;
    logic switch_isolate;
  } chg_drive_t;

endpackage

// ---- tb/cell_model.sv ----
// Purpose: Behavioural cell and regulator seen by the charge sequencer
// Assumes: One charge step per cycle while constant current flows
// Notes:   Bench sets supply, cell presence, float and load directly
`timescale 1ns/100ps
module cell_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire chg_pkg::chg_drive_t drive,
  input wire logic supply_ok,
  input wire logic attached,
  input wire logic stuck,
  input wire logic loaded,
  input wire logic drain,
  input wire logic floating,
  output chg_pkg::chg_sense_t sense
);
  import chg_pkg::*;
  logic [4:0] level_reg;
  // ----------------------------------------
  // Cell charge level
  // ----------------------------------------
  // A damaged cell never rises, so the safety timer can run out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= 5'h00;
    end else if (drain) begin
      level_reg <= 5'h00;
    end else if (drive.mode == REG_CC && !stuck && level_reg != 5'h1F) begin
      level_reg <= level_reg + 5'h01;
    end
  end
  always_comb begin
    sense.input_valid = supply_ok;
    sense.vbat_above_precond = attached && level_reg >= 5'h04;
    sense.vbat_at_term = attached && level_reg >= 5'h08;
    sense.ichg_below_eoc = drive.mode != REG_CC && !loaded;
    sense.battery_present = attached;
    sense.vbat_dropped_restart = drain;
    sense.current_level_floating = floating;
  end
endmodule

// ---- tb/liion_charge_state_machine_test.sv ----
// Purpose: Self-checking bench for the charge sequencer
// Assumes: Minute shortened to ten clock cycles
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/100ps
module liion_charge_state_machine_test;
  import chg_pkg::*;
  localparam logic [31:0] MIN_CYC = 32'h0000000A;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic suspend_req = 1'b1;
  logic [1:0] timer_set = TIMER_SET_60;
  logic [10:0] fast_ma = 11'h0C8;
  logic supply_ok = 1'b1;
  logic attached = 1'b1;
  logic stuck = 1'b0;
  logic loaded = 1'b0;
  logic drain = 1'b0;
  logic floating = 1'b0;
  chg_sense_t sense;
  chg_flags_t flags;
  chg_drive_t drive;
  chg_state_t charge_state;
  logic ind_out;
  logic ind_oe_n;
  int err_count = 0;
  int checked = 0;
  // ----------------------------------------
  // Clock, instances
  // ----------------------------------------
  always #12.5 clock = ~clock;
  charge_ctrl #(.MINUTE_CYCLES(MIN_CYC)) u_charge_ctrl (.clock(clock), .arst_n(arst_n),
    .sense(sense), .charge_suspend_request(suspend_req), .safety_timer_setting(timer_set),
    .fast_current_ma(fast_ma), .flags(flags), .drive(drive), .charge_state(charge_state),
    .charge_indicator_out(ind_out), .charge_indicator_oe_n(ind_oe_n));
  cell_model u_cell_model (.clock(clock), .arst_n(arst_n), .drive(drive),
    .supply_ok(supply_ok), .attached(attached), .stuck(stuck), .loaded(loaded),
    .drain(drain), .floating(floating), .sense(sense));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Bounded wait, so a stuck sequencer ends as a mismatch, not a hang
  task automatic wait_st(input chg_state_t s, input int lim, output int n);
    n = 0;
    while (charge_state !== s && n < lim) begin
      tick(1);
      n++;
    end
    chk("state", s, charge_state);
  endtask
  task automatic chk_on(input logic on, input reg_mode_t m);
    chk("mode", m, drive.mode);
    chk("active flag", on, flags.charging_active_flag);
    chk("indicator oe_n", !on, ind_oe_n);
    chk("indicator data", 1'b0, ind_out);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_block();
    int n;
    chk("suspend hold", ST_SUSPEND, charge_state);
    @(posedge clock);
    suspend_req <= 1'b0;
    floating <= 1'b1;
    tick(5);
    chk("float hold", ST_SUSPEND, charge_state);
    @(posedge clock);
    floating <= 1'b0;
    attached <= 1'b0;
    tick(5);
    chk("no cell flag", 1'b1, flags.battery_missing_flag);
    chk("no cell hold", ST_SUSPEND, charge_state);
    @(posedge clock);
    attached <= 1'b1;
    wait_st(ST_PRECOND, 3, n);
    chk("cell flag", 1'b0, flags.battery_missing_flag);
  endtask
  task automatic t_precond(input logic [10:0] ma);
    int n;
    wait_st(ST_PRECOND, 3, n);
    chk_on(1'b1, REG_CC);
    chk("pre ma", (ma / 10 > 45) ? ma / 10 : 45, drive.current_ma);
    wait_st(ST_FAST, 10, n);
    chk_on(1'b1, REG_CC);
    chk("fast ma", ma, drive.current_ma);
  endtask
  task automatic t_normal();
    int n;
    t_precond(fast_ma);
    wait_st(ST_TOPOFF, 10, n);
    chk_on(1'b1, REG_CV);
    tick(30);
    chk("eoc early", ST_TOPOFF, charge_state);
    @(posedge clock);
    loaded <= 1'b1;
    @(posedge clock);
    loaded <= 1'b0;
    wait_st(ST_SLEEP, 60, n);
    chk("eoc span", 1'b1, n >= 37 && n <= 43);
    chk_on(1'b0, REG_OFF);
    tick(20);
    chk("sleep hold", ST_SLEEP, charge_state);
    @(posedge clock);
    fast_ma <= 11'h3E8;
    drain <= 1'b1;
    @(posedge clock);
    drain <= 1'b0;
    t_precond(11'h3E8);
  endtask
  task automatic t_supply();
    int n;
    @(posedge clock);
    supply_ok <= 1'b0;
    tick(1);
    chk("supply loss", ST_SUSPEND, charge_state);
    chk("isolate", 1'b1, drive.switch_isolate);
    chk_on(1'b0, REG_OFF);
    @(posedge clock);
    supply_ok <= 1'b1;
    wait_st(ST_PRECOND, 3, n);
    chk("isolate off", 1'b0, drive.switch_isolate);
  endtask
  task automatic t_timeout(input logic [1:0] set, input int mins);
    int n;
    int lim;
    lim = mins * int'(MIN_CYC);
    @(posedge clock);
    suspend_req <= 1'b1;
    stuck <= 1'b1;
    drain <= 1'b1;
    timer_set <= set;
    @(posedge clock);
    drain <= 1'b0;
    suspend_req <= 1'b0;
    wait_st(ST_PRECOND, 3, n);
    if (set == TIMER_SET_OFF) begin
      tick(1300);
      chk("timer off", ST_PRECOND, charge_state);
      return;
    end
    wait_st(ST_FAULT, lim + 12, n);
    chk("timeout span", 1'b1, n >= lim - 11 && n <= lim + 2);
    chk("fault flag", 1'b1, flags.timeout_fault_flag);
    chk_on(1'b0, REG_OFF);
    @(posedge clock);
    stuck <= 1'b0;
    tick(30);
    chk("fault hold", ST_FAULT, charge_state);
    @(posedge clock);
    suspend_req <= 1'b1;
    wait_st(ST_SUSPEND, 3, n);
    chk("fault clear", 1'b0, flags.timeout_fault_flag);
  endtask
  task automatic t_reset();
    int n;
    @(posedge clock);
    suspend_req <= 1'b0;
    stuck <= 1'b0;
    wait_st(ST_TOPOFF, 20, n);
    @(posedge clock);
    arst_n <= 1'b0;
    tick(2);
    chk("reset state", ST_SUSPEND, charge_state);
    chk_on(1'b0, REG_OFF);
    @(posedge clock);
    arst_n <= 1'b1;
    wait_st(ST_PRECOND, 3, n);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    tick(2);
    t_block();
    t_normal();
    t_supply();
    t_timeout(TIMER_SET_60, int'(SAFETY_60_MIN));
    t_timeout(TIMER_SET_90, int'(SAFETY_90_MIN));
    t_timeout(TIMER_SET_120, int'(SAFETY_120_MIN));
    t_timeout(TIMER_SET_OFF, 0);
    t_reset();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    end_of_test();
  end
endmodule
